/* File: shared/adros_pkg.sv */
// adros_pkg: register map, field positions, reset values and selector codes
// for the antenna driver output select block.
// assumes a classic Wishbone slave with 32-bit data, 8-bit registers in the low byte.
package adros_pkg;

  // ---------------------------------------------------------------
  // register indices (byte address is four times the index)
  // ---------------------------------------------------------------
  localparam logic [5:0] IDX_DRIVER_CONTROL = 6'h14;
  localparam logic [5:0] IDX_MOD_FORCE = 6'h15;
  localparam logic [5:0] IDX_SOURCE_SELECT = 6'h16;
  localparam logic [5:0] IDX_PIN_STATUS = 6'h1B;

  // ---------------------------------------------------------------
  // reset values
  // ---------------------------------------------------------------
  localparam logic [7:0] RST_DRIVER_CONTROL = 8'h80;
  localparam logic [7:0] RST_MOD_FORCE = 8'h00;
  localparam logic [7:0] RST_SOURCE_SELECT = 8'h10;

  // ---------------------------------------------------------------
  // writable bit masks (reserved bits stay zero)
  // ---------------------------------------------------------------
  localparam logic [7:0] MASK_DRIVER_CONTROL = 8'hFB;
  localparam logic [7:0] MASK_MOD_FORCE = 8'h40;
  localparam logic [7:0] MASK_SOURCE_SELECT = 8'h3F;

  // ---------------------------------------------------------------
  // field positions
  // ---------------------------------------------------------------
  localparam int BIT_INV_B_ON = 7;
  localparam int BIT_INV_A_ON = 6;
  localparam int BIT_INV_B_OFF = 5;
  localparam int BIT_INV_A_OFF = 4;
  localparam int BIT_B_CW = 3;
  localparam int BIT_B_EN = 1;
  localparam int BIT_A_EN = 0;
  localparam int BIT_FORCE_FULL = 6;
  localparam int SRC_MSB = 5;
  localparam int SRC_LSB = 4;
  localparam int AUX_MSB = 3;
  localparam int AUX_LSB = 0;

  // ---------------------------------------------------------------
  // selector codes
  // ---------------------------------------------------------------
  localparam logic [1:0] SRC_HIGHZ = 2'h0;
  localparam logic [1:0] SRC_INTERNAL = 2'h1;
  localparam logic [1:0] SRC_EXTERNAL = 2'h2;
  localparam logic [1:0] SRC_CONST_HIGH = 2'h3;

  localparam logic [3:0] AUX_HIGHZ = 4'h0;
  localparam logic [3:0] AUX_LOW = 4'h1;
  localparam logic [3:0] AUX_HIGH = 4'h2;
  localparam logic [3:0] AUX_TEST_BUS = 4'h3;
  localparam logic [3:0] AUX_ENVELOPE = 4'h4;
  localparam logic [3:0] AUX_TX_SERIAL = 4'h5;
  localparam logic [3:0] AUX_RX_SERIAL = 4'h7;

endpackage

/* File: src/adros_top.sv */
// adros_top: antenna driver output select with its Wishbone register slave.
// assumes carrier and ext modulation arrive from pins; envelope, serial data,
// test bus and power-down come from logic on mclk.
//
// Behaviour
// - enabled driver b inverted when bit 7 set
// - enabled driver a inverted when bit 6 set
// - disabled driver b level inverted by bit 5
// - disabled driver a level inverted by bit 4
// - continuous-carrier bit gives unmodulated carrier on b
// - continuous-carrier clear lets b modulate carrier
// - b enable gives carrier modulated by data
// - a enable gives carrier modulated by data
// - driver control resets to 80h
// - force bit gives full-depth keying
// - modulation force register resets to 00h
// - source 00 high-z, 01 internal envelope
// - power-down high-z only with source 00
// - source 10 takes envelope from ext pin
// - source 11 constant high, inversion applies
// - aux 0000 z, 0001 low, 0010 high, 0100 envelope
// - aux 0011 outputs chosen test bus bit
// - aux 0101 outputs transmit serial data
// - aux 0111 outputs decoded receive data
// - source select resets to 10h
//
// The Wishbone interface to the registers is this design's own decision.
`timescale 1ns/10ps

module adros_top
  import adros_pkg::*;
(
  // clock, reset, enable
  input wire logic mclk,
  input wire logic reset,
  input wire logic clkEn,
  // wishbone slave
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [7:0] adr_i,
  input wire logic [3:0] sel_i,
  input wire logic [31:0] dat_i,
  output logic [31:0] dat_o,
  output logic ack_o,
  // pins from outside the clock domain
  input wire logic carrierIn,
  input wire logic extModulationIn,
  // internal sources on mclk
  input wire logic millerEnvelope,
  input wire logic txSerialData,
  input wire logic rxSerialData,
  input wire logic [7:0] testBus,
  input wire logic [2:0] testBusBitChoice,
  input wire logic softPowerDown,
  // antenna drivers and aux pin, enables active low
  output logic antennaOutA,
  output logic antennaOutAEn_n,
  output logic antennaOutB,
  output logic antennaOutBEn_n,
  output logic auxDigitalOut,
  output logic auxDigitalOutEn_n,
  output logic forceFullDepthKeying
);

  // ---------------------------------------------------------------
  // registers and synchronisers
  // ---------------------------------------------------------------
  logic [7:0] driverControl;
  logic [7:0] modForce;
  logic [7:0] sourceSelect;
  logic carrierMeta;
  logic carrierSync;
  logic extModMeta;
  logic extModSync;

  logic [5:0] wbIndex;
  logic wbRequest;
  logic wbWrite;

  assign wbIndex = adr_i[7:2];
  assign wbRequest = cyc_i && stb_i && !ack_o;
  // a write lands on the edge where the master sees ack
  assign wbWrite = cyc_i && stb_i && we_i && ack_o && sel_i[0];

  // field views
  logic invBOn;
  logic invAOn;
  logic invBOff;
  logic invAOff;
  logic bContinuous;
  logic bEnable;
  logic aEnable;
  logic [1:0] driverSource;
  logic [3:0] auxSelector;

  assign invBOn = driverControl[BIT_INV_B_ON];
  assign invAOn = driverControl[BIT_INV_A_ON];
  assign invBOff = driverControl[BIT_INV_B_OFF];
  assign invAOff = driverControl[BIT_INV_A_OFF];
  assign bContinuous = driverControl[BIT_B_CW];
  assign bEnable = driverControl[BIT_B_EN];
  assign aEnable = driverControl[BIT_A_EN];
  assign driverSource = sourceSelect[SRC_MSB:SRC_LSB];
  assign auxSelector = sourceSelect[AUX_MSB:AUX_LSB];

  // ---------------------------------------------------------------
  // helper: level of one driver pin
  // ---------------------------------------------------------------
  // the carrier is gated by the envelope when enabled; when disabled the
  // pin rests low, and each state has its own inversion bit
  function automatic logic drv_level(input logic enabled, input logic modulated,
                                     input logic invOn, input logic invOff);
    logic lvl;
    lvl = enabled ? (modulated ^ invOn) : invOff;
    return lvl;
  endfunction

  // ---------------------------------------------------------------
  // pin synchronisers
  // ---------------------------------------------------------------
  // two stages; only the second stage feeds logic
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      carrierMeta <= 1'b0;
      carrierSync <= 1'b0;
      extModMeta <= 1'b0;
      extModSync <= 1'b0;
    end else if (clkEn) begin
      carrierMeta <= carrierIn;
      carrierSync <= carrierMeta;
      extModMeta <= extModulationIn;
      extModSync <= extModMeta;
    end
  end

  // ---------------------------------------------------------------
  // register writes
  // ---------------------------------------------------------------
  // reset values
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      driverControl <= RST_DRIVER_CONTROL;
      modForce <= RST_MOD_FORCE;
      sourceSelect <= RST_SOURCE_SELECT;
    end else if (clkEn && wbWrite) begin
      if (wbIndex == IDX_DRIVER_CONTROL) begin
        driverControl <= dat_i[7:0] & MASK_DRIVER_CONTROL;
      end
      if (wbIndex == IDX_MOD_FORCE) begin
        modForce <= dat_i[7:0] & MASK_MOD_FORCE;
      end
      if (wbIndex == IDX_SOURCE_SELECT) begin
        sourceSelect <= dat_i[7:0] & MASK_SOURCE_SELECT;
      end
    end
  end

  // ---------------------------------------------------------------
  // bus answer: ack one cycle after the request, dropped the next
  // ---------------------------------------------------------------
  // unmapped addresses still ack, reading zero, so a stray access never hangs
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      ack_o <= 1'b0;
      dat_o <= 32'h0000_0000;
    end else if (clkEn) begin
      ack_o <= wbRequest;
      if (wbRequest) begin
        unique case (wbIndex)
          IDX_DRIVER_CONTROL: dat_o <= {24'h00_0000, driverControl};
          IDX_MOD_FORCE: dat_o <= {24'h00_0000, modForce};
          IDX_SOURCE_SELECT: dat_o <= {24'h00_0000, sourceSelect};
          IDX_PIN_STATUS: dat_o <= {24'h00_0000, 4'h0, extModSync, auxDigitalOut,
                                    antennaOutB, antennaOutA};
          default: dat_o <= 32'h0000_0000;
        endcase
      end
    end
  end

  // ---------------------------------------------------------------
  // envelope selection
  // ---------------------------------------------------------------
  logic envelope;
  logic driversActive;

  always_comb begin
    unique case (driverSource)
      SRC_HIGHZ: envelope = 1'b0;
      SRC_INTERNAL: envelope = millerEnvelope;
      SRC_EXTERNAL: envelope = extModSync;
      SRC_CONST_HIGH: envelope = 1'b1;
    endcase
  end

  // in power-down the drivers fall back to their disabled level
  assign driversActive = !softPowerDown;

  // ---------------------------------------------------------------
  // antenna drivers
  // ---------------------------------------------------------------
  // forced full-depth flag passed to the analog stage
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      forceFullDepthKeying <= 1'b0;
    end else if (clkEn) begin
      forceFullDepthKeying <= modForce[BIT_FORCE_FULL];
    end
  end

  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      antennaOutA <= 1'b0;
    end else if (clkEn) begin
      antennaOutA <= drv_level(aEnable && driversActive, carrierSync && envelope,
                               invAOn, invAOff);
    end
  end

  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      antennaOutB <= 1'b0;
    end else if (clkEn) begin
      antennaOutB <= drv_level(bEnable && driversActive,
                               carrierSync && (bContinuous || envelope),
                               invBOn, invBOff);
    end
  end

  // high-z only with source code 00
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      antennaOutAEn_n <= 1'b1;
      antennaOutBEn_n <= 1'b1;
    end else if (clkEn) begin
      antennaOutAEn_n <= (driverSource == SRC_HIGHZ);
      antennaOutBEn_n <= (driverSource == SRC_HIGHZ);
    end
  end

  // ---------------------------------------------------------------
  // auxiliary output pin
  // ---------------------------------------------------------------
  logic next_aux;
  logic next_auxEn_n;

  // aux routing
  // reserved codes float the pin rather than guess a source
  always_comb begin
    next_aux = 1'b0;
    next_auxEn_n = 1'b0;
    unique case (auxSelector)
      AUX_LOW: next_aux = 1'b0;
      AUX_HIGH: next_aux = 1'b1;
      AUX_TEST_BUS: next_aux = testBus[testBusBitChoice];
      AUX_ENVELOPE: next_aux = millerEnvelope;
      AUX_TX_SERIAL: next_aux = txSerialData;
      AUX_RX_SERIAL: next_aux = rxSerialData;
      default: next_auxEn_n = 1'b1;
    endcase
  end

  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      auxDigitalOut <= 1'b0;
      auxDigitalOutEn_n <= 1'b1;
    end else if (clkEn) begin
      auxDigitalOut <= next_aux;
      auxDigitalOutEn_n <= next_auxEn_n;
    end
  end

  // ---------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------
  property p_inv_b_on;
    @(posedge mclk) disable iff (reset)
      clkEn && bEnable && !softPowerDown && driverSource == SRC_CONST_HIGH && invBOn
      |=> antennaOutB == !$past(carrierSync);
  endproperty
  a_inv_b_on: assert property (p_inv_b_on) else $error("b not inverted when on");

  property p_inv_a_on;
    @(posedge mclk) disable iff (reset)
      clkEn && aEnable && !softPowerDown && driverSource == SRC_CONST_HIGH && invAOn
      |=> antennaOutA == !$past(carrierSync);
  endproperty
  a_inv_a_on: assert property (p_inv_a_on) else $error("a not inverted when on");

  property p_off_b;
    @(posedge mclk) disable iff (reset)
      clkEn && !bEnable |=> antennaOutB == $past(invBOff);
  endproperty
  a_off_b: assert property (p_off_b) else $error("b disabled level wrong");

  property p_off_a;
    @(posedge mclk) disable iff (reset)
      clkEn && !aEnable |=> antennaOutA == $past(invAOff);
  endproperty
  a_off_a: assert property (p_off_a) else $error("a disabled level wrong");

  property p_cw;
    @(posedge mclk) disable iff (reset)
      clkEn && bEnable && bContinuous && !softPowerDown
      |=> antennaOutB == ($past(carrierSync) ^ $past(invBOn));
  endproperty
  a_cw: assert property (p_cw) else $error("b carrier not continuous");

  property p_mod_a;
    @(posedge mclk) disable iff (reset)
      clkEn && aEnable && !softPowerDown && !invAOn && driverSource == SRC_EXTERNAL
      |=> antennaOutA == ($past(carrierSync) && $past(extModSync));
  endproperty
  a_mod_a: assert property (p_mod_a) else $error("a not modulated by ext pin");

  property p_reset_vals;
    @(posedge mclk) $fell(reset) |-> driverControl == RST_DRIVER_CONTROL
      && modForce == RST_MOD_FORCE && sourceSelect == RST_SOURCE_SELECT;
  endproperty
  a_reset_vals: assert property (p_reset_vals) else $error("reset values wrong");

  property p_highz;
    @(posedge mclk) disable iff (reset)
      !reset && clkEn ##1 clkEn |-> antennaOutAEn_n == ($past(driverSource) == SRC_HIGHZ)
      && antennaOutBEn_n == antennaOutAEn_n;
  endproperty
  a_highz: assert property (p_highz) else $error("driver enable wrong");

  property p_aux_test;
    @(posedge mclk) disable iff (reset)
      clkEn && auxSelector == AUX_TEST_BUS
      |=> !auxDigitalOutEn_n && auxDigitalOut == $past(testBus[testBusBitChoice]);
  endproperty
  a_aux_test: assert property (p_aux_test) else $error("aux test bus wrong");

  property p_reserved;
    @(posedge mclk) disable iff (reset)
      (driverControl & ~MASK_DRIVER_CONTROL) == 8'h00
      && (sourceSelect & ~MASK_SOURCE_SELECT) == 8'h00;
  endproperty
  a_reserved: assert property (p_reserved) else $error("reserved bit set");

  property p_ack;
    @(posedge mclk) disable iff (reset)
      clkEn && wbRequest ##1 clkEn |-> ack_o ##1 (!ack_o || !clkEn);
  endproperty
  a_ack: assert property (p_ack) else $error("ack timing wrong");

  c_cw: cover property (@(posedge mclk) disable iff (reset) bContinuous && bEnable);
  c_ext: cover property (@(posedge mclk) disable iff (reset)
    driverSource == SRC_EXTERNAL && aEnable);
  c_rx: cover property (@(posedge mclk) disable iff (reset) auxSelector == AUX_RX_SERIAL);
  c_pd: cover property (@(posedge mclk) disable iff (reset) softPowerDown && aEnable);

endmodule

/* File: verif/adros_antenna_model.sv */
// adros_antenna_model: antenna circuit and card side of the driver pins.
// assumes the bench picks carrier and external envelope levels on mclk edges.
`timescale 1ns/10ps

module adros_antenna_model (
  // clock
  input wire logic mclk,
  // levels requested by the bench
  input wire logic carrierLevel,
  input wire logic envelopeLevel,
  // driver pins from the device
  input wire logic antennaOutA,
  input wire logic antennaOutAEn_n,
  input wire logic antennaOutB,
  input wire logic antennaOutBEn_n,
  // pins toward the device and sensed coil levels
  output logic carrierIn,
  output logic extModulationIn,
  output logic coilA,
  output logic coilB
);
  // ---------------------------------------------------------------
  // carrier and envelope sources
  // ---------------------------------------------------------------
  // held steady between checks, so the pin synchroniser cannot blur them
  always_ff @(posedge mclk) begin
    carrierIn <= carrierLevel;
    extModulationIn <= envelopeLevel;
  end

  // released driver lines fall to the coil pull-down, never keep a value
  assign coilA = antennaOutAEn_n ? 1'b0 : antennaOutA;
  assign coilB = antennaOutBEn_n ? 1'b0 : antennaOutB;
endmodule

/* File: verif/antenna_driver_output_select_bench.sv */
// antenna_driver_output_select_bench: register and pin checks of adros_top.
// assumes the antenna model on the driver pins and a Wishbone master here.
`timescale 1ns/10ps

module antenna_driver_output_select_bench;
  import adros_pkg::*;
  // model edge, two sync edges and the driver flop, with margin
  localparam int SETTLE = 5;
  localparam logic [7:0] TEST_PATTERN = 8'hA5;
  logic mclk, reset, clkEn, cyc_i, stb_i, we_i, ack_o;
  logic [7:0] adr_i, rd;
  logic [3:0] sel_i;
  logic [31:0] dat_i, dat_o;
  logic carrierIn, extModulationIn, carrierLevel, envelopeLevel, coilA, coilB;
  logic millerEnvelope, txSerialData, rxSerialData, softPowerDown;
  logic [7:0] testBus;
  logic [2:0] testBusBitChoice;
  logic antennaOutA, antennaOutAEn_n, antennaOutB, antennaOutBEn_n;
  logic auxDigitalOut, auxDigitalOutEn_n, forceFullDepthKeying;
  logic [7:0] ctrlTab [6] = '{8'h00, 8'h03, 8'hC3, 8'h0B, 8'hF0, 8'hCB};
  int checks = 0;
  int fail_count = 0;

  // ---------------------------------------------------------------
  // device and far side
  // ---------------------------------------------------------------
  adros_top dut_u (.mclk(mclk), .reset(reset), .clkEn(clkEn), .cyc_i(cyc_i),
    .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i),
    .dat_o(dat_o), .ack_o(ack_o), .carrierIn(carrierIn),
    .extModulationIn(extModulationIn), .millerEnvelope(millerEnvelope),
    .txSerialData(txSerialData), .rxSerialData(rxSerialData), .testBus(testBus),
    .testBusBitChoice(testBusBitChoice), .softPowerDown(softPowerDown),
    .antennaOutA(antennaOutA), .antennaOutAEn_n(antennaOutAEn_n),
    .antennaOutB(antennaOutB), .antennaOutBEn_n(antennaOutBEn_n),
    .auxDigitalOut(auxDigitalOut), .auxDigitalOutEn_n(auxDigitalOutEn_n),
    .forceFullDepthKeying(forceFullDepthKeying));

  adros_antenna_model partner_u (.mclk(mclk), .carrierLevel(carrierLevel),
    .envelopeLevel(envelopeLevel), .antennaOutA(antennaOutA),
    .antennaOutAEn_n(antennaOutAEn_n), .antennaOutB(antennaOutB),
    .antennaOutBEn_n(antennaOutBEn_n), .carrierIn(carrierIn),
    .extModulationIn(extModulationIn), .coilA(coilA), .coilB(coilB));

  // ---------------------------------------------------------------
  // clock, verdict and watchdog
  // ---------------------------------------------------------------
  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end

  task automatic print_verdict();
    $display("checks %0d fail_count %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  // whole run is near 3000 cycles
  initial begin
    repeat (20000) @(posedge mclk);
    fail_count++;
    print_verdict();
  end

  // ---------------------------------------------------------------
  // compares and bus cycles
  // ---------------------------------------------------------------
  task automatic checkBit(input string name, input logic exp, input logic got);
    checks++;
    if (got !== exp) begin
      fail_count++;
      $display("wrong value %s expected %b seen %b", name, exp, got);
    end
  endtask

  task automatic checkByte(input string name, input logic [7:0] exp, input logic [7:0] got);
    checks++;
    if (got !== exp) begin
      fail_count++;
      $display("wrong value %s expected %h seen %h", name, exp, got);
    end
  endtask

  // classic single cycle; read data taken at the ack edge only
  task automatic wbCycle(input logic wr, input logic [7:0] adr, input logic [7:0] wd);
    int n;
    n = 0;
    @(posedge mclk);
    cyc_i <= 1'b1;
    stb_i <= 1'b1;
    we_i <= wr;
    adr_i <= adr;
    sel_i <= 4'hF;
    dat_i <= {24'h000000, wd};
    do begin
      @(posedge mclk);
      n++;
    end while (ack_o !== 1'b1 && n < 50);
    rd = dat_o[7:0];
    cyc_i <= 1'b0;
    stb_i <= 1'b0;
    we_i <= 1'b0;
    if (n >= 50) begin
      checkBit("ack", 1'b1, ack_o);
    end
  endtask

  task automatic checkDrivers(input logic [7:0] ctl, input logic [1:0] src, input logic [3:0] v);
    logic env, expA, expB, hiz;
    hiz = (src == 2'b00);
    env = (src == 2'b01) ? v[1] : (src == 2'b10) ? v[2] : (src == 2'b11);
    expA = (ctl[0] & ~v[3]) ? ((v[0] & env) ^ ctl[6]) : ctl[4];
    expB = (ctl[1] & ~v[3]) ? ((v[0] & (env | ctl[3])) ^ ctl[7]) : ctl[5];
    checkBit("driver a enable_n", hiz, antennaOutAEn_n);
    checkBit("driver b enable_n", hiz, antennaOutBEn_n);
    checkBit("coil a", hiz ? 1'b0 : expA, coilA);
    checkBit("coil b", hiz ? 1'b0 : expB, coilB);
  endtask

  task automatic checkAux(input logic [3:0] a, input logic [2:0] v);
    logic drv, lvl;
    drv = (a >= 4'h1 && a <= 4'h5) || a == 4'h7;
    case (a)
      4'h1: lvl = 1'b0;
      4'h2: lvl = 1'b1;
      4'h3: lvl = TEST_PATTERN[v];
      4'h4: lvl = v[0];
      4'h5: lvl = v[1];
      default: lvl = v[2];
    endcase
    checkBit("aux enable_n", ~drv, auxDigitalOutEn_n);
    if (drv) begin
      checkBit("aux level", lvl, auxDigitalOut);
    end
  endtask

  // ---------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------
  initial begin
    reset = 1'b1;
    clkEn = 1'b1;
    {cyc_i, stb_i, we_i, adr_i, sel_i, dat_i} = '0;
    {carrierLevel, envelopeLevel, millerEnvelope, txSerialData} = '0;
    {rxSerialData, softPowerDown, testBusBitChoice} = '0;
    testBus = TEST_PATTERN;
    repeat (16) @(posedge mclk);
    reset <= 1'b0;
    wbCycle(1'b0, 8'h50, 8'h00);
    checkByte("driver control reset", 8'h80, rd);
    wbCycle(1'b0, 8'h54, 8'h00);
    checkByte("modulation force reset", 8'h00, rd);
    wbCycle(1'b0, 8'h58, 8'h00);
    checkByte("source select reset", 8'h10, rd);
    // reserved bits and an unmapped word swallow all-ones writes
    for (int i = 0; i < 4; i++) begin
      wbCycle(1'b1, 8'h4C + 8'(4 * i), 8'hFF);
      wbCycle(1'b0, 8'h4C + 8'(4 * i), 8'h00);
      checkByte("masked readback", (i == 0) ? 8'h00 : (i == 1) ? 8'hFB :
        (i == 2) ? 8'h40 : 8'h3F, rd);
    end
    @(posedge mclk);
    checkBit("full depth on", 1'b1, forceFullDepthKeying);
    wbCycle(1'b1, 8'h54, 8'h00);
    // write lands on the ack edge, the output flop follows one edge later
    repeat (2) @(posedge mclk);
    checkBit("full depth off", 1'b0, forceFullDepthKeying);
    // every source code against enables, inversions and power-down
    for (int c = 0; c < 6; c++) begin
      for (int s = 0; s < 4; s++) begin
        wbCycle(1'b1, 8'h50, ctrlTab[c]);
        wbCycle(1'b1, 8'h58, {2'b00, s[1:0], 4'h1});
        for (int v = 0; v < 16; v++) begin
          carrierLevel <= v[0];
          millerEnvelope <= v[1];
          envelopeLevel <= v[2];
          softPowerDown <= v[3];
          repeat (SETTLE) @(posedge mclk);
          checkDrivers(ctrlTab[c], s[1:0], 4'(v));
        end
      end
    end
    // every aux selector code, reserved ones included
    for (int a = 0; a < 16; a++) begin
      wbCycle(1'b1, 8'h58, {4'h1, a[3:0]});
      for (int v = 0; v < 8; v++) begin
        millerEnvelope <= v[0];
        txSerialData <= v[1];
        rxSerialData <= v[2];
        testBusBitChoice <= v[2:0];
        repeat (SETTLE) @(posedge mclk);
        checkAux(a[3:0], v[2:0]);
      end
    end
    // pin status: power-down rests both drivers at their off level, aux low, ext high
    wbCycle(1'b0, 8'h6C, 8'h00);
    checkByte("pin status", 8'h08, rd);
    // clock enable low freezes the drivers, then they follow again
    clkEn <= 1'b0;
    softPowerDown <= 1'b0;
    carrierLevel <= 1'b0;
    repeat (SETTLE) @(posedge mclk);
    checkBit("frozen a", 1'b0, antennaOutA);
    clkEn <= 1'b1;
    repeat (SETTLE) @(posedge mclk);
    checkBit("thawed a", 1'b1, antennaOutA);
    print_verdict();
  end
endmodule
